// file: rtl/crxf_defs.svh
// Register offsets, field positions, reset values and sizes of the CAN receive FIFO block
`ifndef CRXF_DEFS_SVH
`define CRXF_DEFS_SVH
`define CRXF_DEPTH          5
`define CRXF_BUF_BYTES      15
`define CRXF_OFF_CTL0       6'h00
`define CRXF_OFF_CTL1       6'h01
`define CRXF_OFF_BTR0       6'h02
`define CRXF_OFF_BTR1       6'h03
`define CRXF_OFF_STAT       6'h04
`define CRXF_OFF_IDAC       6'h05
`define CRXF_OFF_RXERR      6'h06
`define CRXF_OFF_TXERR      6'h07
`define CRXF_OFF_PAT0       6'h10
`define CRXF_OFF_MSK0       6'h18
`define CRXF_OFF_FOREGROUND_RX_BUFFER       6'h20
`define CRXF_CTL0_INIT_MODE_REQUEST    0
`define CRXF_CTL0_PDOWN     1
`define CRXF_CTL1_INIT_MODE_ACK    0
`define CRXF_CTL1_LOOPB     5
`define CRXF_CTL1_ENABLE    7
`define CRXF_STAT_RXF       0
`define CRXF_STAT_OVR       1
`define CRXF_IDAC_MODE_LSB  4
`define CRXF_IDAC_HIT_LSB   0
`define CRXF_CTL1_RST       8'h01
`define CRXF_IDAC_RST       8'h00
`endif

// file: rtl/crxf_pkg.sv
// Types shared by the CAN receive FIFO block
package crxf_pkg;
    typedef enum logic [1:0] {
        CRXF_F32   = 2'h0,
        CRXF_F16   = 2'h1,
        CRXF_F8    = 2'h2,
        CRXF_CLOSE = 2'h3
    } crxf_mode_t;
    typedef enum logic [1:0] {
        CRXF_IDLE = 2'h0,
        CRXF_RECV = 2'h1,
        CRXF_DONE = 2'h3
    } crxf_state_t;
    // One received frame as the link layer hands it over
    typedef struct packed {
        logic [31:0] id_bytes;
        logic [3:0]  dlc;
        logic [63:0] data;
        logic [15:0] stamp;
    } crxf_frame_t;
    // Frame-level status from the bit engine
    typedef struct packed {
        logic sof;
        logic eof_ok;
        logic err;
        logic own_tx;
        logic arb_lost;
    } crxf_link_t;
endpackage : crxf_pkg

// file: rtl/crxf_core.sv
// CAN receive FIFO with acceptance filter and protection logic
//
// Functional notes
// - five-deep FIFO, CPU sees foreground only
// - each buffer holds fifteen bytes
// - full flag means foreground holds accepted message
// - valid frame enters FIFO, flag set, interrupt
// - next frame captured right after interframe
// - rejected or errored frames never enter FIFO
// - own transmitted frame not stored or acked
// - loopback treats own frame as received
// - lost arbitration turns node into receiver
// - full FIFO discards frame, flags overrun
// - accept again once a buffer frees
// - pattern bits, mask bit set means ignore
// - lowest matching filter number reported
// - 32-bit mode gives two filters
// - 16-bit mode gives four filters
// - 8-bit mode gives eight filters
// - closed mode never stores frames
// - error counters ignore all writes
// - configuration writable only in init mode
// - transmit output recessive in init, power-down
// - enable bit accepts first write only
`include "crxf_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module crxf_core (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [5:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    input  wire crxf_pkg::crxf_link_t link,
    input  wire crxf_pkg::crxf_frame_t frame,
    input  wire logic                 tx_bit,
    input  wire logic [7:0]           rx_err_cnt,
    input  wire logic [7:0]           tx_err_cnt,
    output logic                      can_tx_output,
    output logic                      ack_enable,
    output logic                      rx_irq,
    output logic                      ovr_irq
);
    localparam int BB = `CRXF_BUF_BYTES;
    localparam int DEPTH = `CRXF_DEPTH;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] control_reg_0_ff;
    logic [7:0] control_reg_1_ff;
    logic [7:0] bit_timing_reg_0_ff;
    logic [7:0] bit_timing_reg_1_ff;
    logic [7:0] id_accept_control_ff;
    logic [7:0] id_accept_pattern_regs_ff [8];
    logic [7:0] id_accept_mask_regs_ff [8];
    logic       enable_written_ff;
    logic       init_mode_ack;
    logic       wr_cfg;
    logic       fifo_push;
    logic [2:0] hit_idx;
    logic [2:0] count_ff;
    assign init_mode_ack = control_reg_1_ff[`CRXF_CTL1_INIT_MODE_ACK];
    assign wr_cfg = reg_wr && init_mode_ack;

    // Control 0: init request and power-down are free to write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control_reg_0_ff <= 8'h01;
        end else if (reg_wr && reg_addr == `CRXF_OFF_CTL0) begin
            control_reg_0_ff <= reg_wdata;
        end
    end

    // Control 1: ack follows request; bits 6:1 locked outside init, enable bit takes its first write in any mode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control_reg_1_ff  <= `CRXF_CTL1_RST;
            enable_written_ff <= 1'b0;
        end else begin
            control_reg_1_ff[`CRXF_CTL1_INIT_MODE_ACK] <= control_reg_0_ff[`CRXF_CTL0_INIT_MODE_REQUEST];
            if (wr_cfg && reg_addr == `CRXF_OFF_CTL1) begin
                control_reg_1_ff[6:1] <= reg_wdata[6:1];
            end
            if (reg_wr && reg_addr == `CRXF_OFF_CTL1 && !enable_written_ff) begin
                control_reg_1_ff[`CRXF_CTL1_ENABLE] <= reg_wdata[`CRXF_CTL1_ENABLE];
                enable_written_ff                   <= 1'b1;
            end
        end
    end

    // Timing, acceptance control and filter banks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_timing_reg_0_ff  <= 8'h00;
            bit_timing_reg_1_ff  <= 8'h00;
            id_accept_control_ff <= `CRXF_IDAC_RST;
            for (int i = 0; i < 8; i++) begin
                id_accept_pattern_regs_ff[i] <= 8'h00;
                id_accept_mask_regs_ff[i]    <= 8'h00;
            end
        end else begin
            if (wr_cfg) begin
                if (reg_addr == `CRXF_OFF_BTR0) bit_timing_reg_0_ff <= reg_wdata;
                if (reg_addr == `CRXF_OFF_BTR1) bit_timing_reg_1_ff <= reg_wdata;
                if (reg_addr == `CRXF_OFF_IDAC) id_accept_control_ff[5:4] <= reg_wdata[5:4];
                if (reg_addr[5:3] == 3'h2) id_accept_pattern_regs_ff[reg_addr[2:0]] <= reg_wdata;
                if (reg_addr[5:3] == 3'h3) id_accept_mask_regs_ff[reg_addr[2:0]] <= reg_wdata;
            end
            if (fifo_push) id_accept_control_ff[2:0] <= hit_idx;
        end
    end

    // ------------------------------------------------------------------
    // Acceptance filter
    // ------------------------------------------------------------------
    crxf_pkg::crxf_mode_t mode;
    logic [7:0] byte_ok;
    logic [7:0] hits;
    logic [7:0] id_sel [8];
    logic       hit_any;
    assign mode = crxf_pkg::crxf_mode_t'(id_accept_control_ff[5:4]);

    always_comb begin
        for (int b = 0; b < 8; b++) begin
            // Narrow filters all look at the top identifier bytes, not the low ones
            case (mode)
                crxf_pkg::CRXF_F16: id_sel[b] = frame.id_bytes[31-8*(b%2) -: 8];
                crxf_pkg::CRXF_F8:  id_sel[b] = frame.id_bytes[31:24];
                default:            id_sel[b] = frame.id_bytes[31-8*(b%4) -: 8];
            endcase
            byte_ok[b] = &(~(id_sel[b] ^ id_accept_pattern_regs_ff[b]) | id_accept_mask_regs_ff[b]);
        end
    end

    always_comb begin
        hits = 8'h00;
        case (mode)
            crxf_pkg::CRXF_F32: begin
                hits[0] = &byte_ok[3:0];
                hits[1] = &byte_ok[7:4];
            end
            crxf_pkg::CRXF_F16: begin
                hits[0] = &byte_ok[1:0];
                hits[1] = &byte_ok[3:2];
                hits[2] = &byte_ok[5:4];
                hits[3] = &byte_ok[7:6];
            end
            crxf_pkg::CRXF_F8: hits = byte_ok;
            default: hits = 8'h00;
        endcase
    end

    always_comb begin
        hit_idx = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (hits[k]) hit_idx = 3'(k);
        end
    end
    assign hit_any = |hits;

    // ------------------------------------------------------------------
    // Background capture and frame qualification
    // ------------------------------------------------------------------
    crxf_pkg::crxf_state_t rx_state_ff;
    crxf_pkg::crxf_frame_t background_rx_buffer_ff;
    logic own_frame_ff;
    logic loopback;
    logic frame_ok;
    logic overrun;
    assign loopback = control_reg_1_ff[`CRXF_CTL1_LOOPB];
    assign frame_ok = rx_state_ff == crxf_pkg::CRXF_RECV && link.eof_ok && !link.err;

    // Frame tracking; a start of frame begins capture from idle or done, and while a frame is in progress only reloads the own-frame flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_state_ff  <= crxf_pkg::CRXF_IDLE;
            own_frame_ff <= 1'b0;
        end else begin
            case (rx_state_ff)
                crxf_pkg::CRXF_IDLE: begin
                    if (link.sof) rx_state_ff <= crxf_pkg::CRXF_RECV;
                end
                crxf_pkg::CRXF_RECV: begin
                    if (link.eof_ok || link.err) rx_state_ff <= crxf_pkg::CRXF_DONE;
                end
                crxf_pkg::CRXF_DONE: begin
                    rx_state_ff <= link.sof ? crxf_pkg::CRXF_RECV : crxf_pkg::CRXF_IDLE;
                end
                default: rx_state_ff <= crxf_pkg::CRXF_IDLE;
            endcase
            if (link.sof) own_frame_ff <= link.own_tx;
            else if (link.arb_lost) own_frame_ff <= 1'b0;
        end
    end

    // overwrite background on each end of frame
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            background_rx_buffer_ff <= '0;
        end else if (rx_state_ff == crxf_pkg::CRXF_RECV && link.eof_ok) begin
            background_rx_buffer_ff <= frame;
        end
    end

    logic accept;
    assign accept = frame_ok && hit_any && (!own_frame_ff || loopback) && !init_mode_ack;
    assign fifo_push = accept && count_ff != 3'(DEPTH);
    assign overrun   = accept && count_ff == 3'(DEPTH);

    // ------------------------------------------------------------------
    // Five-entry FIFO, foreground at read pointer
    // ------------------------------------------------------------------
    // storage
    logic [8*BB-1:0] fifo_mem_ff [DEPTH];
    logic [2:0] wptr_ff;
    logic [2:0] rptr_ff;
    logic       rx_full_flag;
    logic       pop;
    logic [8*BB-1:0] foreground_rx_buffer;
    assign rx_full_flag = count_ff != 3'h0;
    assign foreground_rx_buffer = fifo_mem_ff[rptr_ff];
    assign pop = reg_wr && reg_addr == `CRXF_OFF_STAT && reg_wdata[`CRXF_STAT_RXF] && rx_full_flag;

    // Store pushes frame bytes: id, dlc, data, stamp
    always_ff @(posedge sys_clk) begin
        if (fifo_push) begin
            fifo_mem_ff[wptr_ff] <= {frame.id_bytes, 4'h0, frame.dlc, frame.data, frame.stamp};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wptr_ff  <= 3'h0;
            rptr_ff  <= 3'h0;
            count_ff <= 3'h0;
        end else begin
            if (fifo_push) wptr_ff <= (wptr_ff == 3'(DEPTH - 1)) ? 3'h0 : wptr_ff + 3'h1;
            if (pop) rptr_ff <= (rptr_ff == 3'(DEPTH - 1)) ? 3'h0 : rptr_ff + 3'h1;
            count_ff <= count_ff + 3'(fifo_push) - 3'(pop);
        end
    end

    // ------------------------------------------------------------------
    // Status, interrupts and pins
    // ------------------------------------------------------------------
    logic ovr_flag_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ovr_flag_ff <= 1'b0;
        end else if (overrun) begin
            ovr_flag_ff <= 1'b1;
        end else if (reg_wr && reg_addr == `CRXF_OFF_STAT && reg_wdata[`CRXF_STAT_OVR]) begin
            ovr_flag_ff <= 1'b0;
        end
    end

    // interrupt and recessive pin, all registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_irq        <= 1'b0;
            ovr_irq       <= 1'b0;
            can_tx_output <= 1'b1;
            ack_enable    <= 1'b0;
        end else begin
            rx_irq  <= (count_ff != 3'h0 && !(pop && count_ff == 3'h1)) || fifo_push;
            ovr_irq <= ovr_flag_ff || overrun;
            can_tx_output <= (control_reg_0_ff[`CRXF_CTL0_INIT_MODE_REQUEST] || init_mode_ack
                              || control_reg_0_ff[`CRXF_CTL0_PDOWN]) ? 1'b1 : tx_bit;
            ack_enable <= !(own_frame_ff && !loopback) && !init_mode_ack;
        end
    end

    // ------------------------------------------------------------------
    // Register read port; error counters are read only
    // ------------------------------------------------------------------
    // counters ignore writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CRXF_OFF_CTL0:  reg_rdata <= control_reg_0_ff;
                `CRXF_OFF_CTL1:  reg_rdata <= control_reg_1_ff;
                `CRXF_OFF_BTR0:  reg_rdata <= bit_timing_reg_0_ff;
                `CRXF_OFF_BTR1:  reg_rdata <= bit_timing_reg_1_ff;
                `CRXF_OFF_STAT:  reg_rdata <= {6'h00, ovr_flag_ff, rx_full_flag};
                `CRXF_OFF_IDAC:  reg_rdata <= id_accept_control_ff;
                `CRXF_OFF_RXERR: reg_rdata <= rx_err_cnt;
                `CRXF_OFF_TXERR: reg_rdata <= tx_err_cnt;
                default: begin
                    if (reg_addr[5:3] == 3'h2) reg_rdata <= id_accept_pattern_regs_ff[reg_addr[2:0]];
                    else if (reg_addr[5:3] == 3'h3) reg_rdata <= id_accept_mask_regs_ff[reg_addr[2:0]];
                    else if (reg_addr >= `CRXF_OFF_FOREGROUND_RX_BUFFER && reg_addr < 6'h2F)
                        reg_rdata <= foreground_rx_buffer[8*BB-1-8*(reg_addr-`CRXF_OFF_FOREGROUND_RX_BUFFER) -: 8];
                    else reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence clear_flag_s;
        pop && count_ff == 3'h1 && !fifo_push;
    endsequence

    fifo_bound_a: assert property (@(posedge sys_clk) disable iff (rst) count_ff <= 3'(DEPTH))
        else $error("fifo count above depth");
    push_count_a: assert property (@(posedge sys_clk) disable iff (rst)
        fifo_push && !pop |=> count_ff == $past(count_ff) + 3'h1)
        else $error("push did not add an entry");
    full_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
        count_ff == 3'(DEPTH) |-> !fifo_push)
        else $error("push into full fifo");
    closed_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
        mode == crxf_pkg::CRXF_CLOSE |-> !fifo_push)
        else $error("closed filter stored frame");
    own_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
        own_frame_ff && !loopback |-> !fifo_push)
        else $error("own frame stored");
    flag_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        clear_flag_s |=> !rx_full_flag && !rx_irq)
        else $error("flag stayed after last clear");
    tx_recessive_a: assert property (@(posedge sys_clk) disable iff (rst)
        init_mode_ack |=> can_tx_output)
        else $error("tx not recessive in init");
    cfg_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
        !init_mode_ack && !$past(init_mode_ack) |-> $stable(bit_timing_reg_0_ff))
        else $error("timing changed outside init");
    enable_once_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(enable_written_ff) |-> $stable(control_reg_1_ff[`CRXF_CTL1_ENABLE]))
        else $error("enable changed twice");
    hit_lowest_a: assert property (@(posedge sys_clk) disable iff (rst)
        fifo_push && hits[0] |=> id_accept_control_ff[2:0] == 3'h0)
        else $error("lowest hit not reported");
    no_self_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
        own_frame_ff && !loopback |=> !ack_enable)
        else $error("own frame acknowledged");
    ovr_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        overrun |=> ovr_flag_ff)
        else $error("overrun not flagged");
    init_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        init_mode_ack |-> !fifo_push)
        else $error("frame stored in init mode");
endmodule : crxf_core
`default_nettype wire

// file: testbench/crxf_bus_node.sv
// Behavioural bit engine standing in for the other nodes on the bus
`timescale 1ns/1ns
`default_nettype none
module crxf_bus_node (
    input  wire logic                 sys_clk,
    output var  crxf_pkg::crxf_link_t  link_ff,
    output var  crxf_pkg::crxf_frame_t frame_ff
);
    // ------------------------------------------------------------
    // Idle bus: no pulses, frame lines carry junk
    // ------------------------------------------------------------
    initial begin
        link_ff  = '0;
        frame_ff = '1;
    end
    // back-to-back frames
    // Start pulse, body of 2+gap cycles, then end or error pulse; a later call follows straight on
    task automatic send(input logic [31:0] id, input logic [7:0] tag, input logic own,
                        input logic lost, input logic bad, input int gap);
        @(posedge sys_clk);
        link_ff <= '{1'b1, 1'b0, 1'b0, own, 1'b0};
        @(posedge sys_clk);
        link_ff <= '{1'b0, 1'b0, 1'b0, 1'b0, lost};
        repeat (1 + gap) @(posedge sys_clk) link_ff <= '0;
        @(posedge sys_clk);
        link_ff  <= '{1'b0, ~bad, bad, 1'b0, 1'b0};
        frame_ff <= '{id, 4'h8, {8{tag}}, 16'h5A3C};
        // Frame valid with the end pulse only; inverted after so stale use shows
        @(posedge sys_clk);
        link_ff  <= '0;
        frame_ff <= ~frame_ff;
    endtask : send
endmodule : crxf_bus_node
`default_nettype wire

// file: testbench/can_rx_fifo_acceptance_filter_tb.sv
// Self-checking bench for the CAN receive FIFO and acceptance filter
`include "crxf_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module can_rx_fifo_acceptance_filter_tb;
    logic                  sys_clk, rst, reg_wr, reg_rd, tx_bit;
    logic                  can_tx_output, ack_enable, rx_irq, ovr_irq;
    logic [5:0]            reg_addr;
    logic [7:0]            reg_wdata, reg_rdata, rx_err_cnt, tx_err_cnt, d;
    crxf_pkg::crxf_link_t  link;
    crxf_pkg::crxf_frame_t frame;
    int                    num_errors, n_checks, k;
    logic [31:0]           ids [3] = '{32'hEEFF1234, 32'h34AA55BB, 32'hAA34BBCC};
    logic [7:0]            hits [3] = '{8'h13, 8'h21, 8'h00};

    crxf_core crxf_core_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link), .frame(frame),
        .tx_bit(tx_bit), .rx_err_cnt(rx_err_cnt), .tx_err_cnt(tx_err_cnt),
        .can_tx_output(can_tx_output), .ack_enable(ack_enable), .rx_irq(rx_irq), .ovr_irq(ovr_irq));
    crxf_bus_node crxf_bus_node_i (.sys_clk(sys_clk), .link_ff(link), .frame_ff(frame));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Register bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rc(input string name, input logic [5:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk(name, d, e);
    endtask : rc
    task automatic pop;
        wr(`CRXF_OFF_STAT, 8'h01);
    endtask : pop
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Bounded poll of the init acknowledge bit
    task automatic wait_ack(input logic v);
        int n;
        n = 0;
        d = 8'h00;
        while (n < 10 && (n == 0 || d[0] !== v)) begin
            @(posedge sys_clk);
            reg_rd <= 1'b1; reg_addr <= `CRXF_OFF_CTL1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 d = reg_rdata;
            n++;
        end
        chk("init_ack", {7'h0, d[0]}, {7'h0, v});
        if (d[0] !== v) tally_and_finish();
    endtask : wait_ack
    // Enter init, load filter setup, go back on-line
    task automatic cfg(input logic [7:0] idac, input logic [7:0] ctl1, input logic [63:0] pat,
                       input logic [63:0] msk);
        wr(`CRXF_OFF_CTL0, 8'h01);
        wait_ack(1'b1);
        chk("tx_init", {7'h0, can_tx_output}, 8'h01);
        wr(`CRXF_OFF_IDAC, idac);
        wr(`CRXF_OFF_CTL1, ctl1);
        wr(`CRXF_OFF_BTR0, 8'h21);
        for (int i = 0; i < 8; i++) begin
            wr(6'(`CRXF_OFF_PAT0 + i), pat[63 - 8 * i -: 8]);
            wr(6'(`CRXF_OFF_MSK0 + i), msk[63 - 8 * i -: 8]);
        end
        wr(`CRXF_OFF_CTL0, 8'h00);
        wait_ack(1'b0);
    endtask : cfg
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 6'h00; reg_wdata = 8'h00;
        tx_bit = 1'b0; rx_err_cnt = 8'h3C; tx_err_cnt = 8'hC3; num_errors = 0; n_checks = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rc("ctl0", `CRXF_OFF_CTL0, 8'h01);
        rc("ctl1", `CRXF_OFF_CTL1, `CRXF_CTL1_RST);
        rc("idac", `CRXF_OFF_IDAC, `CRXF_IDAC_RST);
        rc("status", `CRXF_OFF_STAT, 8'h00);
        chk("tx_reset", {7'h0, can_tx_output}, 8'h01);
        $display("test reset done");
        // Byte 3 of bank 0 masked as don't care
        cfg(8'h00, 8'h80, 64'h123456789ABCDEF0, 64'h000000FF00000000);
        chk("tx_online", {7'h0, can_tx_output}, 8'h00);
        wr(`CRXF_OFF_BTR0, 8'h55);
        rc("btr0_lock", `CRXF_OFF_BTR0, 8'h21);
        wr(`CRXF_OFF_IDAC, 8'h30);
        rc("idac_lock", `CRXF_OFF_IDAC, 8'h00);
        wr(`CRXF_OFF_CTL1, 8'h00);
        rc("ctl1_lock", `CRXF_OFF_CTL1, 8'h80);
        wr(`CRXF_OFF_RXERR, 8'h00);
        rc("rx_err", `CRXF_OFF_RXERR, 8'h3C);
        wr(`CRXF_OFF_TXERR, 8'hFF);
        rc("tx_err", `CRXF_OFF_TXERR, 8'hC3);
        $display("test lock done");
        crxf_bus_node_i.send(32'h9ABCDEF0, 8'h11, 1'b0, 1'b0, 1'b0, 0);
        rc("status", `CRXF_OFF_STAT, 8'h01);
        rc("hit", `CRXF_OFF_IDAC, 8'h01);
        chk("rx_irq", {7'h0, rx_irq}, 8'h01);
        rc("fg_id", 6'h20, 8'h9A);
        rc("fg_dlc", 6'h24, 8'h08);
        rc("fg_data", 6'h25, 8'h11);
        rc("fg_stamp", 6'h2E, 8'h3C);
        pop();
        rc("status", `CRXF_OFF_STAT, 8'h00);
        crxf_bus_node_i.send(32'h123456AA, 8'h22, 1'b0, 1'b0, 1'b0, 2);
        rc("hit_mask", `CRXF_OFF_IDAC, 8'h00);
        pop();
        crxf_bus_node_i.send(32'h00000000, 8'h33, 1'b0, 1'b0, 1'b0, 0);
        rc("miss", `CRXF_OFF_STAT, 8'h00);
        crxf_bus_node_i.send(32'h9ABCDEF0, 8'h33, 1'b0, 1'b0, 1'b1, 0);
        rc("err", `CRXF_OFF_STAT, 8'h00);
        crxf_bus_node_i.send(32'h9ABCDEF0, 8'h33, 1'b1, 1'b0, 1'b0, 0);
        rc("own", `CRXF_OFF_STAT, 8'h00);
        chk("ack_own", {7'h0, ack_enable}, 8'h00);
        crxf_bus_node_i.send(32'h9ABCDEF0, 8'h44, 1'b1, 1'b1, 1'b0, 0);
        rc("arb_lost", `CRXF_OFF_STAT, 8'h01);
        chk("ack_rx", {7'h0, ack_enable}, 8'h01);
        pop();
        $display("test filter done");
        // Back-to-back frames fill all five entries, the sixth overruns
        for (k = 0; k < 6; k++) crxf_bus_node_i.send(32'h9ABCDEF0, k[7:0], 1'b0, 1'b0, 1'b0, k % 2);
        rc("full", `CRXF_OFF_STAT, 8'h03);
        chk("ovr_irq", {7'h0, ovr_irq}, 8'h01);
        rc("fg_old", 6'h25, 8'h00);
        pop();
        crxf_bus_node_i.send(32'h9ABCDEF0, 8'h09, 1'b0, 1'b0, 1'b0, 0);
        for (k = 1; k < 6; k++) begin
            rc("fg_order", 6'h25, (k == 5) ? 8'h09 : k[7:0]);
            pop();
        end
        rc("drained", `CRXF_OFF_STAT, 8'h02);
        chk("rx_irq_off", {7'h0, rx_irq}, 8'h00);
        wr(`CRXF_OFF_STAT, 8'h02);
        rc("ovr_clr", `CRXF_OFF_STAT, 8'h00);
        chk("ovr_irq_off", {7'h0, ovr_irq}, 8'h00);
        $display("test overrun done");
        // 16-bit, 8-bit and closed modes, own frames looped back
        for (k = 0; k < 3; k++) begin
            cfg({2'h0, 2'(k + 1), 4'h0}, 8'h20, 64'hAA34BBCCDD34EEFF, 64'h0);
            rc("ctl1_once", `CRXF_OFF_CTL1, 8'hA0);
            crxf_bus_node_i.send(ids[k], 8'h77, 1'b1, 1'b0, 1'b0, 0);
            rc("mode_status", `CRXF_OFF_STAT, (k == 2) ? 8'h00 : 8'h01);
            if (k < 2) rc("mode_hit", `CRXF_OFF_IDAC, hits[k]);
            pop();
        end
        wr(`CRXF_OFF_CTL0, 8'h02);
        rc("pdown", `CRXF_OFF_CTL0, 8'h02);
        chk("tx_pdown", {7'h0, can_tx_output}, 8'h01);
        $display("test modes done");
        tally_and_finish();
    end
endmodule : can_rx_fifo_acceptance_filter_tb
`default_nettype wire
